// ===== hdl/blks_band_lock_key.sv
// Band access control, key store and inline media cipher
`timescale 1ns/100ps
`include "blks_regs.svh"
module blks_band_lock_key import blks_pkg::*; #(
  parameter int NPORT = 2,
  parameter int NBAND = 16,
  // Arbitrary factory credential, made per unit at manufacture
  parameter logic [`BLKS_KEY_W-1:0] FACTORY_CRED = {8{32'h5a3c_96e1}}
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire blks_req_t mediaReq [NPORT],
  output blks_rsp_t mediaRsp [NPORT],
  input wire logic powerLossIn,
  input wire logic entropyIn,
  output logic fwDownloadEnable,
  output logic ready
);
  initial begin
    if (NBAND != `BLKS_MAX_BANDS || NPORT < 1)
      $error("blks_band_lock_key: unsupported NBAND or NPORT");
  end

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [`BLKS_BLK_W-1:0] encBlk(
      input logic [`BLKS_BLK_W-1:0] x, input logic [`BLKS_KEY_W-1:0] k);
    logic [`BLKS_BLK_W-1:0] t;
    t = x ^ k[`BLKS_BLK_W-1:0];
    return {t[`BLKS_BLK_W-`BLKS_ROT-1:0], t[`BLKS_BLK_W-1 -: `BLKS_ROT]}
           ^ k[`BLKS_KEY_W-1:`BLKS_BLK_W];
  endfunction

  function automatic logic [`BLKS_BLK_W-1:0] decBlk(
      input logic [`BLKS_BLK_W-1:0] y, input logic [`BLKS_KEY_W-1:0] k);
    logic [`BLKS_BLK_W-1:0] t;
    t = y ^ k[`BLKS_KEY_W-1:`BLKS_BLK_W];
    return {t[`BLKS_ROT-1:0], t[`BLKS_BLK_W-1:`BLKS_ROT]}
           ^ k[`BLKS_BLK_W-1:0];
  endfunction

  function automatic logic [3:0] bandOf(input blks_table_t tb,
      input logic [`BLKS_LBA_W-1:0] lba);
    logic [3:0] b;
    b = 4'h0;
    for (int i = 1; i < `BLKS_MAX_BANDS; i++) begin
      if (tb[i].enabled && tb[i].allocated && lba >= tb[i].first &&
          lba <= tb[i].last)
        b = 4'(i);
    end
    return b;
  endfunction

  // ---------------------------------------------------------------
  // State, storage and synchronisers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_WRAP = 3'b001, S_KEYS = 3'b010, S_RUN = 3'b100
  } blks_state_t;
  blks_state_t state;
  logic [3:0] initIdx;
  blks_table_t bands;
  logic [`BLKS_KEY_W-1:0] keyStore [`BLKS_MAX_BANDS];
  logic [`BLKS_KEY_W-1:0] credStore [`BLKS_NCRED];
  logic [`BLKS_KEY_W-1:0] wrapKey, random_source, randHold, presCred, newCred;
  logic [`BLKS_LBA_W-1:0] argStart, argLen;
  logic [2:0] argCfg;
  logic [3:0] infoBand;
  logic stOk, stAuthFail, stRefused;
  logic [1:0] plSync, enSync;
  logic plLast;
  logic powerLossEvt;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      plSync <= 2'h0;
      enSync <= 2'h0;
      plLast <= 1'b0;
    end else begin
      plSync <= {plSync[0], powerLossIn};
      enSync <= {enSync[0], entropyIn};
      plLast <= plSync[1];
    end
  end
  assign powerLossEvt = plSync[1] && !plLast;

  // Random source: 256-bit LFSR stirred by the entropy pin
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) random_source <= {8{32'h1357_9bdf}};
    else random_source <= {random_source[`BLKS_KEY_W-2:0], random_source[255] ^ random_source[253] ^ random_source[250]
                 ^ random_source[245] ^ enSync[1]};
  end

  // ---------------------------------------------------------------
  // Command decode and authorisation
  // ---------------------------------------------------------------
  logic cmdGo, authMatch, permit, rangeBad, cmdOk;
  blks_op_t cmdOp;
  blks_auth_t cmdAuth;
  logic [3:0] cmdBand;
  logic [4:0] credIdx;
  logic [`BLKS_LBA_W:0] endSum;
  logic [`BLKS_LBA_W-1:0] newLast;

  always_comb begin
    cmdGo = wr && addr == `BLKS_OFF_CMD && state == S_RUN;
    cmdOp = blks_op_t'(wdata[`BLKS_CMD_OP]);
    cmdAuth = blks_auth_t'(wdata[`BLKS_CMD_AUTH]);
    cmdBand = wdata[`BLKS_CMD_BAND];
    credIdx = `BLKS_CRED_BAND0 + 5'(cmdBand);
    unique case (cmdAuth)
      AUTH_OWNER: authMatch = presCred == credStore[`BLKS_CRED_OWNER] ||
                              presCred == FACTORY_CRED;
      AUTH_FACTORY: authMatch = presCred == FACTORY_CRED;
      AUTH_ERASE: authMatch = presCred == credStore[`BLKS_CRED_ERASE];
      AUTH_BAND: authMatch = presCred == credStore[credIdx];
    endcase
    unique case (cmdOp)
      OP_FWDL_ON, OP_FWDL_OFF:
        permit = cmdAuth == AUTH_OWNER || cmdAuth == AUTH_FACTORY;
      OP_ENABLE: permit = cmdAuth == AUTH_ERASE;
      OP_UNLOCK, OP_LOCK, OP_SETRANGE, OP_ERASE, OP_SETCFG:
        permit = cmdAuth == AUTH_ERASE || cmdAuth == AUTH_BAND;
      OP_SETCRED: permit = cmdAuth != AUTH_FACTORY;
      OP_RANDOM: permit = 1'b1;
      default: permit = 1'b0;
    endcase
    endSum = {1'b0, argStart} + {1'b0, argLen} - 33'h1;
    newLast = endSum[`BLKS_LBA_W-1:0];
    rangeBad = 1'b0;
    if (cmdOp == OP_SETRANGE && argLen != '0) begin
      if (cmdBand == 4'h0 || endSum[`BLKS_LBA_W] ||
          (cmdBand > 4'h1 && !bands[cmdBand].enabled))
        rangeBad = 1'b1;
      for (int i = 1; i < `BLKS_MAX_BANDS; i++) begin
        if (4'(i) != cmdBand && bands[i].allocated &&
            argStart <= bands[i].last && bands[i].first <= newLast)
          rangeBad = 1'b1;
      end
    end
    cmdOk = cmdGo && permit && (authMatch || cmdOp == OP_RANDOM) &&
            !rangeBad;
  end

  // Command result flags
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stOk <= 1'b0;
      stAuthFail <= 1'b0;
      stRefused <= 1'b0;
    end else if (cmdGo) begin
      stOk <= cmdOk;
      stAuthFail <= !(permit && (authMatch || cmdOp == OP_RANDOM));
      stRefused <= rangeBad;
    end
  end

  // ---------------------------------------------------------------
  // Power-up sequence: wrap key with relock evaluation, then band keys
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= S_WRAP;
      initIdx <= 4'h0;
      ready <= 1'b0;
    end else begin
      unique case (state)
        S_WRAP: state <= S_KEYS;
        S_KEYS: begin
          initIdx <= initIdx + 4'h1;
          if (initIdx == 4'(NBAND - 1)) begin
            state <= S_RUN;
            ready <= 1'b1;
          end
        end
        S_RUN: state <= S_RUN;
      endcase
    end
  end

  // Key store holds only wrapped keys
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wrapKey <= '0;
      for (int i = 0; i < `BLKS_MAX_BANDS; i++) keyStore[i] <= '0;
    end else begin
      if (state == S_WRAP) wrapKey <= {random_source[127:0], random_source[255:128]};
      if (state == S_KEYS) keyStore[initIdx] <= random_source ^ wrapKey;
      if (cmdOk && cmdOp == OP_ERASE)
        keyStore[cmdBand] <= random_source ^ wrapKey;
    end
  end

  // Credentials, factory value after reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `BLKS_NCRED; i++)
        credStore[i] <= FACTORY_CRED;
    end else if (cmdOk && cmdOp == OP_SETCRED) begin
      unique case (cmdAuth)
        AUTH_OWNER: credStore[`BLKS_CRED_OWNER] <= newCred;
        AUTH_ERASE: credStore[`BLKS_CRED_ERASE] <= newCred;
        AUTH_BAND: credStore[credIdx] <= newCred;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) fwDownloadEnable <= 1'b1;
    else if (cmdOk && cmdOp == OP_FWDL_ON) fwDownloadEnable <= 1'b1;
    else if (cmdOk && cmdOp == OP_FWDL_OFF) fwDownloadEnable <= 1'b0;
  end

  // Band table
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `BLKS_MAX_BANDS; i++) begin
        bands[i] <= '0;
        bands[i].last <= '1;
      end
      bands[0].enabled <= 1'b1;
      bands[0].allocated <= 1'b1;
      bands[1].enabled <= 1'b1;
    end else begin
      if (cmdOk) begin
        unique case (cmdOp)
          OP_UNLOCK: bands[cmdBand].locked <= 1'b0;
          OP_LOCK: bands[cmdBand].locked <= 1'b1;
          OP_ENABLE: bands[cmdBand].enabled <= 1'b1;
          OP_SETCFG: begin
            bands[cmdBand].readGuard <= argCfg[`BLKS_CFG_RG];
            bands[cmdBand].writeGuard <= argCfg[`BLKS_CFG_WG];
            bands[cmdBand].relockPwr <= argCfg[`BLKS_CFG_PWR];
          end
          OP_SETRANGE: begin
            bands[cmdBand].first <= argStart;
            bands[cmdBand].last <= newLast;
            bands[cmdBand].allocated <= argLen != '0;
          end
          default: ;
        endcase
      end
      // Placed last so a power-loss lock wins over a same-cycle unlock
      for (int i = 0; i < `BLKS_MAX_BANDS; i++) begin
        if ((state == S_WRAP || powerLossEvt) && bands[i].relockPwr &&
            bands[i].readGuard && bands[i].writeGuard)
          bands[i].locked <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  logic [2:0] win;
  logic [2:0] widx;
  logic [15:0] lockMask;
  assign win = addr[7:5];
  assign widx = addr[4:2];

  always_comb begin
    for (int i = 0; i < `BLKS_MAX_BANDS; i++) lockMask[i] = bands[i].locked;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      presCred <= '0;
      newCred <= '0;
      argStart <= '0;
      argLen <= '0;
      argCfg <= 3'h0;
      infoBand <= 4'h0;
      randHold <= '0;
    end else begin
      if (wr && win == `BLKS_WIN_PRES) presCred[widx*32 +: 32] <= wdata;
      if (wr && win == `BLKS_WIN_NEW) newCred[widx*32 +: 32] <= wdata;
      if (wr && addr == `BLKS_OFF_START) argStart <= wdata;
      if (wr && addr == `BLKS_OFF_LENGTH) argLen <= wdata;
      if (wr && addr == `BLKS_OFF_CFG) argCfg <= wdata[2:0];
      if (wr && addr == `BLKS_OFF_CMD) infoBand <= cmdBand;
      if (cmdOk && cmdOp == OP_RANDOM) randHold <= random_source;
    end
  end

  // Keys have no read path; presented and new credential windows read back as zero, the factory window returns FACTORY_CRED
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) rdata <= '0;
    else if (rd) begin
      rdata <= '0;
      if (addr == `BLKS_OFF_STATUS) begin
        rdata[`BLKS_ST_OK] <= stOk;
        rdata[`BLKS_ST_AUTHFAIL] <= stAuthFail;
        rdata[`BLKS_ST_REFUSED] <= stRefused;
        rdata[`BLKS_ST_READY] <= ready;
        rdata[`BLKS_ST_FWDL] <= fwDownloadEnable;
        rdata[`BLKS_ST_LOCKED] <= lockMask;
      end
      if (addr == `BLKS_OFF_START) rdata <= bands[infoBand].first;
      if (addr == `BLKS_OFF_LENGTH) rdata <= bands[infoBand].last;
      if (addr == `BLKS_OFF_BANDINFO)
        rdata[5:0] <= {bands[infoBand].enabled, bands[infoBand].allocated,
                       bands[infoBand].readGuard, bands[infoBand].writeGuard,
                       bands[infoBand].relockPwr, bands[infoBand].locked};
      if (win == `BLKS_WIN_RAND) rdata <= randHold[widx*32 +: 32];
      if (win == `BLKS_WIN_FACT)
        rdata <= FACTORY_CRED[widx*32 +: 32];
    end
  end

  // ---------------------------------------------------------------
  // Media cipher engines, one per port
  // ---------------------------------------------------------------
  logic [3:0] reqBand [NPORT];
  logic [`BLKS_KEY_W-1:0] plainKey [NPORT];
  logic [`BLKS_BLK_W-1:0] chainIv [NPORT];

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic [`BLKS_BLK_W-1:0] ivUse, cipherOut;
    always_comb begin
      reqBand[p] = bandOf(bands, mediaReq[p].lba);
      plainKey[p] = keyStore[reqBand[p]] ^ wrapKey;
      ivUse = mediaReq[p].first ? {4{mediaReq[p].lba}} : chainIv[p];
      cipherOut = encBlk(mediaReq[p].data ^ ivUse, plainKey[p]);
    end
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        chainIv[p] <= '0;
        mediaRsp[p] <= '0;
      end else begin
        mediaRsp[p].valid <= mediaReq[p].valid;
        mediaRsp[p].band <= reqBand[p];
        mediaRsp[p].refused <= mediaReq[p].valid &&
            (!ready || bands[reqBand[p]].locked);
        mediaRsp[p].data <= mediaReq[p].write ? cipherOut :
            decBlk(mediaReq[p].data, plainKey[p]) ^ ivUse;
        if (mediaReq[p].valid)
          chainIv[p] <= mediaReq[p].write ? cipherOut : mediaReq[p].data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [5:0] upCount;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) upCount <= 6'h0;
    else if (!ready) upCount <= upCount + 6'h1;
  end

  property p_locked_refused;
    @(posedge mclk) disable iff (!resetn)
    mediaReq[0].valid && bands[reqBand[0]].locked |=> mediaRsp[0].refused;
  endproperty
  a_locked_refused: assert property (p_locked_refused)
    else $error("access to locked band not refused");

  property p_early_refused;
    @(posedge mclk) disable iff (!resetn)
    mediaReq[0].valid && !ready |=> mediaRsp[0].valid && mediaRsp[0].refused;
  endproperty
  a_early_refused: assert property (p_early_refused)
    else $error("media access taken before power-up checks");

  property p_ready_bound;
    @(posedge mclk) disable iff (!resetn) upCount <= 6'd18;
  endproperty
  a_ready_bound: assert property (p_ready_bound)
    else $error("power-up sequence too long");

  property p_auth_fail;
    @(posedge mclk) disable iff (!resetn)
    cmdGo && cmdOp != OP_RANDOM && !authMatch |=> stAuthFail && !stOk;
  endproperty
  a_auth_fail: assert property (p_auth_fail)
    else $error("command without credential accepted");

  property p_erase_newkey;
    @(posedge mclk) disable iff (!resetn)
    cmdOk && cmdOp == OP_ERASE |=>
      keyStore[$past(cmdBand)] != $past(keyStore[cmdBand]);
  endproperty
  a_erase_newkey: assert property (p_erase_newkey)
    else $error("erase left the band key unchanged");

  property p_relock;
    @(posedge mclk) disable iff (!resetn)
    powerLossEvt && bands[1].relockPwr && bands[1].readGuard &&
      bands[1].writeGuard |=> bands[1].locked;
  endproperty
  a_relock: assert property (p_relock)
    else $error("band not locked on power loss");

  property p_no_relock;
    @(posedge mclk) disable iff (!resetn)
    powerLossEvt && !(bands[2].relockPwr && bands[2].readGuard &&
      bands[2].writeGuard) && !bands[2].locked &&
      !(cmdGo && cmdOp == OP_LOCK) |=> !bands[2].locked;
  endproperty
  a_no_relock: assert property (p_no_relock)
    else $error("band locked without all relock conditions");

  property p_fwdl_factory;
    @(posedge mclk) disable iff (!resetn) $rose(ready) |-> fwDownloadEnable;
  endproperty
  a_fwdl_factory: assert property (p_fwdl_factory)
    else $error("firmware download not enabled at power-up");

  property p_overlap;
    @(posedge mclk) disable iff (!resetn)
    cmdGo && cmdOp == OP_SETRANGE && rangeBad |=>
      stRefused && bands[infoBand] == $past(bands[cmdBand]);
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("refused range still applied");

  property p_fact_read;
    @(posedge mclk) disable iff (!resetn)
    rd && addr == {`BLKS_WIN_FACT, 5'h0} |=> rdata == FACTORY_CRED[31:0];
  endproperty
  a_fact_read: assert property (p_fact_read)
    else $error("factory credential read wrong");

  c_refused: cover property (@(posedge mclk) disable iff (!resetn)
    mediaRsp[0].valid && mediaRsp[0].refused && ready);
  c_erase: cover property (@(posedge mclk) disable iff (!resetn)
    cmdOk && cmdOp == OP_ERASE);
  c_unlock: cover property (@(posedge mclk) disable iff (!resetn)
    cmdOk && cmdOp == OP_UNLOCK && bands[cmdBand].locked);
endmodule // blks_band_lock_key

// ===== pkg/blks_pkg.sv
// Types shared by the band lock and key select block
`include "blks_regs.svh"
package blks_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_UNLOCK = 4'h1, OP_LOCK = 4'h2, OP_SETRANGE = 4'h3,
    OP_ENABLE = 4'h4, OP_ERASE = 4'h5, OP_SETCRED = 4'h6,
    OP_SETCFG = 4'h7, OP_FWDL_ON = 4'h8, OP_FWDL_OFF = 4'h9,
    OP_RANDOM = 4'ha
  } blks_op_t;
  typedef enum logic [1:0] {
    AUTH_OWNER = 2'h0, AUTH_FACTORY = 2'h1, AUTH_ERASE = 2'h2,
    AUTH_BAND = 2'h3
  } blks_auth_t;
  typedef struct packed {
    logic [`BLKS_LBA_W-1:0] first;
    logic [`BLKS_LBA_W-1:0] last;
    logic enabled;
    logic allocated;
    logic readGuard;
    logic writeGuard;
    logic relockPwr;
    logic locked;
  } blks_band_t;
  typedef blks_band_t blks_table_t [`BLKS_MAX_BANDS];
  typedef struct packed {
    logic valid;
    logic write;
    logic first;
    logic [`BLKS_LBA_W-1:0] lba;
    logic [`BLKS_BLK_W-1:0] data;
  } blks_req_t;
  typedef struct packed {
    logic valid;
    logic refused;
    logic [3:0] band;
    logic [`BLKS_BLK_W-1:0] data;
  } blks_rsp_t;
endpackage

// ===== pkg/blks_regs.svh
// Register offsets, fields, codes and counts for the band lock block
`ifndef BLKS_REGS_SVH
`define BLKS_REGS_SVH
// ---------------------------------------------------------------
// Register byte offsets and window numbers
// ---------------------------------------------------------------
`define BLKS_OFF_CMD 8'h00
`define BLKS_OFF_STATUS 8'h04
`define BLKS_OFF_START 8'h08
`define BLKS_OFF_LENGTH 8'h0c
`define BLKS_OFF_CFG 8'h10
`define BLKS_OFF_BANDINFO 8'h14
`define BLKS_WIN_PRES 3'h1
`define BLKS_WIN_NEW 3'h2
`define BLKS_WIN_RAND 3'h3
`define BLKS_WIN_FACT 3'h4
// ---------------------------------------------------------------
// Command, config and status fields, credential indices and count
// ---------------------------------------------------------------
`define BLKS_CMD_BAND 3:0
`define BLKS_CMD_AUTH 9:8
`define BLKS_CMD_OP 15:12
`define BLKS_CFG_RG 0
`define BLKS_CFG_WG 1
`define BLKS_CFG_PWR 2
`define BLKS_ST_OK 0
`define BLKS_ST_AUTHFAIL 1
`define BLKS_ST_REFUSED 2
`define BLKS_ST_READY 3
`define BLKS_ST_FWDL 4
`define BLKS_ST_LOCKED 31:16
`define BLKS_CRED_OWNER 5'd0
`define BLKS_CRED_ERASE 5'd1
`define BLKS_CRED_BAND0 5'd2
`define BLKS_NCRED 18
// ---------------------------------------------------------------
// Widths, cipher constants and band count
// ---------------------------------------------------------------
`define BLKS_LBA_W 32
`define BLKS_KEY_W 256
`define BLKS_BLK_W 128
`define BLKS_ROT 13
`define BLKS_MAX_BANDS 16
`endif

// ===== test/blks_host_model.sv
// Host initiator model driving the register port
`timescale 1ns/100ps
module blks_host_model (
  input wire logic mclk,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  localparam logic [7:0] OUT_OPC = 8'hb5;
  localparam logic [7:0] IN_OPC = 8'ha2;
  initial begin
    addr = 8'hff;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Released lines show the inverse of their last value
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic get(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    addr <= ~a;
  endtask
  task automatic cred(input logic [7:0] b, input logic [31:0] w);
    for (int k = 0; k < 8; k++) put(b + 8'(4 * k), w);
  endtask
  task automatic range(input logic [31:0] s, input logic [31:0] n);
    put(8'h08, s & 32'hffff_f000);
    put(8'h0c, n & 32'hffff_f000);
  endtask
endmodule // blks_host_model

// ===== test/tb_top.sv
// Self-checking bench for the band lock and key select block
`timescale 1ns/100ps
module tb_top;
  import blks_pkg::*;
  localparam logic [31:0] FW = 32'h1357_9bdf; // Arbitrary factory word
  localparam logic [31:0] LBAS [6] = '{32'hfff, 32'h1000, 32'h1fff,
    32'h2000, 32'h2fff, 32'h3000};
  localparam logic [3:0] BNDS [6] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h0};
  typedef struct {logic [31:0] v; logic [31:0] m; logic ne;} blks_rx_t;
  typedef struct {logic rf; logic [3:0] b; logic dk; logic ne;
    logic [127:0] d;} blks_mx_t;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, l;
  logic wr, rd, fwdl, ready, pwr = 1'b0, ent = 1'b0, rdD1 = 1'b0;
  logic [127:0] d, e;
  logic [127:0] lastD [2];
  logic [15:0] lf = 16'd25296;
  blks_req_t mReq [2];
  blks_rsp_t mRsp [2];
  blks_rx_t rq [$];
  blks_mx_t mq [2][$];
  int n_fail = 0;
  int n_checks = 0;
  always #10 mclk = ~mclk;
  blks_band_lock_key #(.NPORT(2), .NBAND(16), .FACTORY_CRED({8{FW}})) uut (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .mediaReq(mReq), .mediaRsp(mRsp),
    .powerLossIn(pwr), .entropyIn(ent), .fwDownloadEnable(fwdl),
    .ready(ready));
  blks_host_model host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [31:0] cw(input blks_op_t o, input blks_auth_t a,
      input logic [3:0] b);
    return {16'h0, o, 2'h0, a, 4'h0, b};
  endfunction
  task automatic cmp(input logic [127:0] g, input logic [127:0] x,
      input logic ne, input string m);
    n_checks++;
    if (ne ? (g === x) : (g !== x)) begin
      n_fail++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
      input logic [31:0] m, input logic ne = 1'b0);
    rq.push_back('{x, m, ne});
    host.get(a);
  endtask
  task automatic cmd(input blks_op_t o, input blks_auth_t a,
      input logic [3:0] b, input logic [31:0] x, input logic [31:0] m);
    host.put(8'h00, cw(o, a, b));
    rdc(8'h04, x, m);
  endtask
  task automatic med(input int p, input logic w, input logic [31:0] la,
      input logic [127:0] dt, input logic rf, input logic [3:0] b,
      input logic dk, input logic ne, input logic [127:0] x);
    mq[p].push_back('{rf, b, dk, ne, x});
    @(posedge mclk);
    mReq[p] <= '{1'b1, w, 1'b1, la, dt};
    @(posedge mclk);
    mReq[p] <= '{1'b0, w, 1'b1, ~la, ~dt};
    @(posedge mclk);
    #1;
  endtask
  task automatic print_verdict;
    if (rq.size() + mq[0].size() + mq[1].size() > 0) begin
      n_fail++;
      $display("MISMATCH t=%0t missing answers", $time);
    end
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Output monitor
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    ent <= ~ent ^ lf[0];
    if (rdD1) begin
      cmp(rdata & rq[0].m, rq[0].v & rq[0].m, rq[0].ne, "read data");
      void'(rq.pop_front());
    end
    rdD1 <= rd;
    for (int p = 0; p < 2; p++) if (mRsp[p].valid === 1'b1) begin
      cmp({mRsp[p].refused, mRsp[p].band}, {mq[p][0].rf, mq[p][0].b},
        1'b0, "media status");
      if (mq[p][0].dk)
        cmp(mRsp[p].data, mq[p][0].d, mq[p][0].ne, "data");
      lastD[p] <= mRsp[p].data;
      void'(mq[p].pop_front());
    end
  end
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    for (int p = 0; p < 2; p++) mReq[p] = '0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    med(0, 1'b1, 32'h0, 128'h0, 1'b1, 4'h0, 1'b0, 1'b0, 128'h0);
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge mclk);
    rdc(8'h04, 32'h18, 32'h18);
    cmp(128'(fwdl), 128'h1, 1'b0, "fwdl pin at start");
    rdc(8'h80, FW, '1);
    rdc(8'h9c, FW, '1);
    rdc(8'h20, 32'h0, '1);
    rdc(8'hfc, 32'h0, '1);
    $display("test factory done");
    lf = lfsr(lf);
    d = {8{lf}};
    l = {lf, 16'h0};
    med(0, 1'b1, l, d, 1'b0, 4'h0, 1'b1, 1'b1, d);
    med(1, 1'b0, l, lastD[0], 1'b0, 4'h0, 1'b1, 1'b0, d);
    med(0, 1'b1, '1, d, 1'b0, 4'h0, 1'b0, 1'b0, d);
    $display("test cipher done");
    host.cred(8'h20, FW);
    host.range(32'h1000, 32'h1000);
    cmd(OP_SETRANGE, AUTH_BAND, 4'h1, 32'h1, 32'h7);
    host.range(32'h8000, 32'h1000);
    cmd(OP_SETRANGE, AUTH_ERASE, 4'h3, 32'h4, 32'h7);
    cmd(OP_ENABLE, AUTH_ERASE, 4'h2, 32'h1, 32'h7);
    host.range(32'h1000, 32'h2000);
    cmd(OP_SETRANGE, AUTH_ERASE, 4'h2, 32'h4, 32'h7);
    host.range(32'h2000, 32'h1000);
    cmd(OP_SETRANGE, AUTH_ERASE, 4'h2, 32'h1, 32'h7);
    rdc(8'h0c, 32'h2fff, '1);
    for (int i = 0; i < 6; i++)
      med(0, 1'b1, LBAS[i], d, 1'b0, BNDS[i], 1'b0, 1'b0, d);
    $display("test bands done");
    host.cred(8'h20, ~FW);
    cmd(OP_LOCK, AUTH_BAND, 4'h1, 32'h2, 32'h7);
    host.cred(8'h20, FW);
    cmd(OP_LOCK, AUTH_BAND, 4'h1, 32'h2_0001, 32'h2_0007);
    med(1, 1'b0, 32'h1000, d, 1'b1, 4'h1, 1'b0, 1'b0, d);
    host.cred(8'h40, ~FW);
    cmd(OP_SETCRED, AUTH_BAND, 4'h1, 32'h1, 32'h7);
    cmd(OP_UNLOCK, AUTH_BAND, 4'h1, 32'h2, 32'h7);
    host.cred(8'h20, ~FW);
    cmd(OP_UNLOCK, AUTH_BAND, 4'h1, 32'h1, 32'h2_0007);
    med(1, 1'b0, 32'h1000, d, 1'b0, 4'h1, 1'b0, 1'b0, d);
    $display("test lock done");
    host.put(8'h10, 32'h7);
    cmd(OP_SETCFG, AUTH_BAND, 4'h1, 32'h1, 32'h7);
    host.cred(8'h20, FW);
    host.put(8'h10, 32'h3);
    cmd(OP_SETCFG, AUTH_ERASE, 4'h2, 32'h1, 32'h7);
    pwr <= 1'b1;
    repeat (6) @(posedge mclk);
    pwr <= 1'b0;
    med(0, 1'b1, 32'h1000, d, 1'b1, 4'h1, 1'b0, 1'b0, d);
    med(0, 1'b1, 32'h2000, d, 1'b0, 4'h2, 1'b0, 1'b0, d);
    rdc(8'h04, 32'h2_0000, 32'h6_0000);
    $display("test power loss done");
    cmd(OP_FWDL_OFF, AUTH_FACTORY, 4'h0, 32'h1, 32'h17);
    cmp(128'(fwdl), 128'h0, 1'b0, "fwdl pin off");
    cmd(OP_FWDL_ON, AUTH_OWNER, 4'h0, 32'h11, 32'h17);
    cmp(128'(fwdl), 128'h1, 1'b0, "fwdl pin on");
    cmd(OP_RANDOM, AUTH_FACTORY, 4'h0, 32'h1, 32'h7);
    rdc(8'h60, 32'h0, '1, 1'b1);
    med(0, 1'b1, l, d, 1'b0, 4'h0, 1'b0, 1'b0, d);
    e = lastD[0];
    cmd(OP_ERASE, AUTH_ERASE, 4'h0, 32'h1, 32'h7);
    med(1, 1'b0, l, e, 1'b0, 4'h0, 1'b1, 1'b1, d);
    $display("test erase done");
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    $display("MISMATCH t=%0t watchdog", $time);
    print_verdict();
  end
endmodule // tb_top
